// ### hw/bar_decode_params.svh
// offsets, reset values and fixed constants of the base address decoder
`ifndef BAR_DECODE_PARAMS_SVH
`define BAR_DECODE_PARAMS_SVH

// i/o base registers, byte offsets in configuration space
`define OFS_CONFIG_PORT     8'h60
`define OFS_EMBEDDED_MEMORY 8'h64
`define OFS_SERIAL_PORT     8'h68
`define OFS_KEYBOARD_CTRL   8'h78
`define OFS_EC_CHAN0        8'h88
`define OFS_EC_CHAN1        8'h8c
`define OFS_POWER_MGMT      8'h90
`define OFS_LEGACY_GATE     8'h94
`define OFS_MESSAGE_BOX     8'h98
`define OFS_CLOCK_CALENDAR  8'h9c

// memory base registers, byte offsets in configuration space
`define OFS_MEM_MESSAGE_BOX 8'hc0
`define OFS_MEM_EC_CHAN0    8'hc6
`define OFS_MEM_EC_CHAN1    8'hcc
`define OFS_MEM_EMBEDDED    8'hd2

// status register of the decoder
`define OFS_DECODE_STATUS   8'hf0
`define STATUS_FAULT_BIT    0
`define STATUS_CONFLICT_BIT 1

// reset values of the i/o base registers
`define RST_CONFIG_PORT     32'h002e0c01
`define RST_EMBEDDED_MEMORY 32'h0000000f
`define RST_SERIAL_PORT     32'h00000707
`define RST_KEYBOARD_CTRL   32'h00600104
`define RST_EC_CHAN0        32'h00620304
`define RST_EC_CHAN1        32'h00660407
`define RST_POWER_MGMT      32'h00000507
`define RST_LEGACY_GATE     32'h00920600
`define RST_MESSAGE_BOX     32'h00000901
`define RST_CLOCK_CALENDAR  32'h00000b3f

// reset values of the memory base registers
`define RST_MEM_MESSAGE_BOX 48'h0000_0000_0901
`define RST_MEM_EC_CHAN0    48'h0000_0062_0304
`define RST_MEM_EC_CHAN1    48'h0000_0066_0407
`define RST_MEM_EMBEDDED    48'h0000_0000_000f

// register sizes in bytes
`define IO_BAR_BYTES        8'h04
`define MEM_BAR_BYTES       8'h06

// field positions
`define FLD_VALID           15
`define FLD_DEVICE          14
`define FLD_FRAME_HI        13
`define FLD_FRAME_LO        8
`define FLD_MASK_HI         7
`define FLD_HOST_LO         16

// decode range used by the legacy units in place of their mask field
`define LEGACY_RANGE_MASK   8'h04

`endif

// ### hw/bar_decode_pkg.sv
// types shared by the base address decoder
package bar_decode_pkg;

	typedef logic [3:0]  unit_idx_t;
	typedef logic [47:0] bar_word_t;

	typedef enum logic {
		LK_IDLE = 1'b0,
		LK_WAIT = 1'b1
	} link_state_t;

endpackage

// ### hw/bar_match_unit.sv
// compare of one base register against a host cycle address
`timescale 1ns/1ps

module bar_match_unit
	import bar_decode_pkg::*;
(
	// register contents
	input  wire logic [31:0] host_addr,
	input  wire logic        valid,
	input  wire logic [7:0]  mask,
	// cycle
	input  wire logic [31:0] cmp_addr,
	input  wire logic        cyc_ok,
	// result
	output logic             hit
);

	logic [31:0] diff;

	// masked bits drop out of the compare
	assign diff = (host_addr ^ cmp_addr) & ~{24'h000000, mask};

	assign hit = valid && cyc_ok && (diff == 32'h00000000);

endmodule

// ### hw/lpc_io_bar_address_decoder.sv
// base address registers and parallel host cycle decode
`timescale 1ns/1ps

`include "bar_decode_params.svh"

module lpc_io_bar_address_decoder
	import bar_decode_pkg::*;
(
	// system clock and main power reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// host domain reset pin, active low
	input  wire logic        host_domain_reset_n,
	// configuration register access, byte wide
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	// reload value for the config port address
	input  wire logic [15:0] bar_init_addr,
	// status
	output logic             host_bus_internal_fault_flag,
	output logic             bar_conflict_flag,
	// link side, on the host bus clock
	input  wire logic        lpc_clk,
	input  wire logic        cyc_start,
	input  wire logic        cyc_mem,
	input  wire logic [31:0] cyc_addr,
	output logic             cyc_done,
	output logic             cyc_claim,
	output logic      [6:0]  logical_unit_number,
	output logic      [23:0] cyc_xlat_addr
);

	localparam int NUM_IO  = 10;
	localparam int NUM_BAR = 14;

	localparam logic [7:0] BAR_OFS [NUM_BAR] = '{
		`OFS_CONFIG_PORT, `OFS_EMBEDDED_MEMORY, `OFS_SERIAL_PORT, `OFS_KEYBOARD_CTRL,
		`OFS_EC_CHAN0, `OFS_EC_CHAN1, `OFS_POWER_MGMT, `OFS_LEGACY_GATE,
		`OFS_MESSAGE_BOX, `OFS_CLOCK_CALENDAR,
		`OFS_MEM_MESSAGE_BOX, `OFS_MEM_EC_CHAN0, `OFS_MEM_EC_CHAN1, `OFS_MEM_EMBEDDED
	};

	localparam bar_word_t BAR_RST [NUM_BAR] = '{
		{16'h0000, `RST_CONFIG_PORT}, {16'h0000, `RST_EMBEDDED_MEMORY},
		{16'h0000, `RST_SERIAL_PORT}, {16'h0000, `RST_KEYBOARD_CTRL},
		{16'h0000, `RST_EC_CHAN0}, {16'h0000, `RST_EC_CHAN1},
		{16'h0000, `RST_POWER_MGMT}, {16'h0000, `RST_LEGACY_GATE},
		{16'h0000, `RST_MESSAGE_BOX}, {16'h0000, `RST_CLOCK_CALENDAR},
		`RST_MEM_MESSAGE_BOX, `RST_MEM_EC_CHAN0, `RST_MEM_EC_CHAN1, `RST_MEM_EMBEDDED
	};

	// units whose range is kept inside the unit itself
	localparam logic [NUM_BAR-1:0] LEGACY_UNIT = 14'h0088;

	// register storage
	logic [31:0]        host_ff [NUM_BAR];
	logic [NUM_BAR-1:0] valid_ff;
	logic [7:0]         shadow_ff;
	logic [7:0]         cfg_rdata_ff;
	logic               fault_ff;
	logic               conflict_ff;
	// host domain reset synchroniser
	logic               hrst_s1_ff;
	logic               hrst_s2_ff;
	logic               hrst_act;
	// configuration decode
	logic               sel_hit;
	unit_idx_t          sel_idx;
	logic [2:0]         sel_byte;
	bar_word_t          sel_word;
	logic               stat_sel;
	// link domain
	link_state_t        lk_state_ff;
	logic               req_tgl_ff;
	logic               mem_hold_ff;
	logic [31:0]        addr_hold_ff;
	logic               ack_s1_ff;
	logic               ack_s2_ff;
	logic               ack_seen_ff;
	logic               cyc_done_ff;
	logic               cyc_claim_ff;
	logic [6:0]         ldn_ff;
	logic [23:0]        xlat_ff;
	// system domain side of the handshake
	logic               req_s1_ff;
	logic               req_s2_ff;
	logic               req_seen_ff;
	logic               req_edge;
	logic               ack_tgl_ff;
	logic               res_claim_ff;
	logic [6:0]         res_ldn_ff;
	logic [23:0]        res_xlat_ff;
	// match results
	logic [NUM_BAR-1:0] hits;
	logic               multi_hit;
	unit_idx_t          win_idx;
	logic [7:0]         win_mask;
	logic [5:0]         win_frame;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// pin idles high, no false host reset after power reset
			hrst_s1_ff <= 1'b1;
			hrst_s2_ff <= 1'b1;
		end else begin
			hrst_s1_ff <= host_domain_reset_n;
			hrst_s2_ff <= hrst_s1_ff;
		end
	end

	assign hrst_act = !hrst_s2_ff;

	always_comb begin
		sel_hit  = 1'b0;
		sel_idx  = 4'h0;
		sel_byte = 3'h0;
		for (int i = 0; i < NUM_BAR; i++) begin
			if (cfg_addr >= BAR_OFS[i] &&
			    cfg_addr < BAR_OFS[i] + (i < NUM_IO ? `IO_BAR_BYTES : `MEM_BAR_BYTES)) begin
				sel_hit  = 1'b1;
				sel_idx  = 4'(i);
				sel_byte = 3'(cfg_addr - BAR_OFS[i]);
			end
		end
	end

	assign stat_sel = (cfg_addr == `OFS_DECODE_STATUS);

	// low address byte of the config port goes to the shadow only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shadow_ff <= 8'h00;
		end else if (cfg_wr && sel_hit && sel_idx == 4'h0 && sel_byte == 3'h2) begin
			shadow_ff <= cfg_wdata;
		end
	end

	// one register per unit; device, frame and mask stay read-only
	for (genvar g = 0; g < NUM_BAR; g++) begin : g_bar
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				host_ff[g]  <= BAR_RST[g][47:16];
				valid_ff[g] <= BAR_RST[g][`FLD_VALID];
			end else if (hrst_act && g == 0) begin
				host_ff[g]  <= {16'h0000, bar_init_addr};
			end else if (hrst_act) begin
				host_ff[g]  <= BAR_RST[g][47:16];
				valid_ff[g] <= BAR_RST[g][`FLD_VALID];
			end else if (cfg_wr && sel_hit && sel_idx == unit_idx_t'(g)) begin
				case (sel_byte)
					3'h1: valid_ff[g] <= cfg_wdata[7];
					3'h2: if (g != 0) host_ff[g][7:0] <= cfg_wdata;
					3'h3: begin
						if (g == 0) host_ff[g][15:0] <= {cfg_wdata, shadow_ff};
						else host_ff[g][15:8] <= cfg_wdata;
					end
					3'h4: host_ff[g][23:16] <= cfg_wdata;
					3'h5: host_ff[g][31:24] <= cfg_wdata;
					default: ;
				endcase
			end
		end

		// io registers see only io cycles, memory registers only memory cycles
		bar_match_unit u_match (
			.host_addr (host_ff[g]),
			.valid     (valid_ff[g]),
			.mask      (LEGACY_UNIT[g] ? `LEGACY_RANGE_MASK : BAR_RST[g][7:0]),
			.cmp_addr  (g < NUM_IO ? {16'h0000, addr_hold_ff[15:0]} : addr_hold_ff),
			.cyc_ok    (g < NUM_IO ? !mem_hold_ff : mem_hold_ff),
			.hit       (hits[g])
		);
	end

	assign sel_word = {host_ff[sel_idx], valid_ff[sel_idx], BAR_RST[sel_idx][14:0]};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_rdata_ff <= 8'h00;
		end else if (cfg_rd) begin
			if (sel_hit) cfg_rdata_ff <= sel_word[8*sel_byte +: 8];
			else if (stat_sel) cfg_rdata_ff <= {6'h00, conflict_ff, fault_ff};
			else cfg_rdata_ff <= 8'h00;
		end
	end

	// lowest numbered hit wins, more than one is a conflict
	always_comb begin
		win_idx   = 4'h0;
		multi_hit = 1'b0;
		for (int i = NUM_BAR - 1; i >= 0; i--) begin
			if (hits[i]) win_idx = 4'(i);
		end
		for (int i = 0; i < NUM_BAR; i++) begin
			if (hits[i] && |(hits & ((14'h0001 << i) - 14'h0001))) multi_hit = 1'b1;
		end
	end

	assign win_mask  = BAR_RST[win_idx][7:0];
	assign win_frame = BAR_RST[win_idx][`FLD_FRAME_HI:`FLD_FRAME_LO];

	// request crossing into the system domain
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_s1_ff   <= 1'b0;
			req_s2_ff   <= 1'b0;
			req_seen_ff <= 1'b0;
		end else begin
			req_s1_ff   <= req_tgl_ff;
			req_s2_ff   <= req_s1_ff;
			req_seen_ff <= req_s2_ff;
		end
	end

	assign req_edge = req_s2_ff ^ req_seen_ff;

	// decode result, held stable until the next request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			res_claim_ff <= 1'b0;
			res_ldn_ff   <= 7'h00;
			res_xlat_ff  <= 24'h000000;
			ack_tgl_ff   <= 1'b0;
		end else if (req_edge) begin
			res_claim_ff <= |hits;
			res_ldn_ff   <= BAR_RST[win_idx][`FLD_DEVICE:`FLD_FRAME_LO];
			res_xlat_ff  <= {8'h00, win_frame, 2'b00, addr_hold_ff[7:0] & win_mask};
			ack_tgl_ff   <= !ack_tgl_ff;
		end
	end

	// sticky flags, a new conflict beats a clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fault_ff    <= 1'b0;
			conflict_ff <= 1'b0;
		end else if (req_edge && multi_hit) begin
			fault_ff    <= 1'b1;
			conflict_ff <= 1'b1;
		end else if (cfg_wr && stat_sel) begin
			if (cfg_wdata[`STATUS_FAULT_BIT]) fault_ff <= 1'b0;
			if (cfg_wdata[`STATUS_CONFLICT_BIT]) conflict_ff <= 1'b0;
		end
	end

	// link side: capture the cycle, wait for the decode
	always_ff @(posedge lpc_clk or posedge rst) begin
		if (rst) begin
			ack_s1_ff   <= 1'b0;
			ack_s2_ff   <= 1'b0;
			ack_seen_ff <= 1'b0;
		end else begin
			ack_s1_ff   <= ack_tgl_ff;
			ack_s2_ff   <= ack_s1_ff;
			ack_seen_ff <= ack_s2_ff;
		end
	end

	always_ff @(posedge lpc_clk or posedge rst) begin
		if (rst) begin
			lk_state_ff  <= LK_IDLE;
			req_tgl_ff   <= 1'b0;
			mem_hold_ff  <= 1'b0;
			addr_hold_ff <= 32'h00000000;
			cyc_done_ff  <= 1'b0;
			cyc_claim_ff <= 1'b0;
			ldn_ff       <= 7'h00;
			xlat_ff      <= 24'h000000;
		end else begin
			cyc_done_ff <= 1'b0;
			case (lk_state_ff)
				LK_IDLE: begin
					if (cyc_start) begin
						mem_hold_ff  <= cyc_mem;
						addr_hold_ff <= cyc_addr;
						req_tgl_ff   <= !req_tgl_ff;
						lk_state_ff  <= LK_WAIT;
					end
				end
				LK_WAIT: begin
					if (ack_s2_ff ^ ack_seen_ff) begin
						cyc_done_ff  <= 1'b1;
						cyc_claim_ff <= res_claim_ff;
						ldn_ff       <= res_ldn_ff;
						xlat_ff      <= res_xlat_ff;
						lk_state_ff  <= LK_IDLE;
					end
				end
				default: lk_state_ff <= LK_IDLE;
			endcase
		end
	end

	assign cfg_rdata                    = cfg_rdata_ff;
	assign host_bus_internal_fault_flag = fault_ff;
	assign bar_conflict_flag            = conflict_ff;
	assign cyc_done                     = cyc_done_ff;
	assign cyc_claim                    = cyc_claim_ff;
	assign logical_unit_number          = ldn_ff;
	assign cyc_xlat_addr                = xlat_ff;

	// checks
	sequence s_cyc_taken;
		lk_state_ff == LK_IDLE && cyc_start;
	endsequence
	sequence s_cyc_answered;
		##[3:40] cyc_done_ff;
	endsequence
	a_cycle_answered: assert property (
		@(posedge lpc_clk) disable iff (rst) s_cyc_taken |-> s_cyc_answered)
		else $error("host cycle not answered in time");
	a_claim_on_hit: assert property (
		@(posedge sys_clk) disable iff (rst) req_edge && |hits |=> res_claim_ff && $changed(ack_tgl_ff))
		else $error("matching cycle not claimed");
	a_unclaimed_miss: assert property (
		@(posedge sys_clk) disable iff (rst) req_edge && hits == 14'h0000 |=> !res_claim_ff)
		else $error("cycle claimed without a match");
	a_overlap_flags: assert property (
		@(posedge sys_clk) disable iff (rst) req_edge && multi_hit |=> fault_ff && conflict_ff)
		else $error("overlap did not set both flags");
	a_shadow_low: assert property (
		@(posedge sys_clk) disable iff (rst)
		cfg_wr && sel_hit && sel_idx == 4'h0 && sel_byte == 3'h2 && !hrst_act
		|=> host_ff[0] == $past(host_ff[0]) && shadow_ff == $past(cfg_wdata))
		else $error("low byte write changed the config port address");
	a_shadow_high: assert property (
		@(posedge sys_clk) disable iff (rst)
		cfg_wr && sel_hit && sel_idx == 4'h0 && sel_byte == 3'h3 && !hrst_act
		|=> host_ff[0][15:0] == {$past(cfg_wdata), $past(shadow_ff)})
		else $error("high byte write did not load the full address");
	a_port_reload: assert property (
		@(posedge sys_clk) disable iff (rst)
		hrst_act |=> host_ff[0][15:0] == $past(bar_init_addr) && valid_ff[0] == $past(valid_ff[0]))
		else $error("config port not reloaded on host reset");
	a_valid_write: assert property (
		@(posedge sys_clk) disable iff (rst) cfg_wr && sel_hit && sel_byte == 3'h1 && !hrst_act
		|=> valid_ff[$past(sel_idx)] == $past(cfg_wdata[7]))
		else $error("valid bit write not taken");
	a_status_read: assert property (
		@(posedge sys_clk) disable iff (rst)
		cfg_rd && stat_sel && !sel_hit |=> cfg_rdata_ff == {6'h00, $past(conflict_ff), $past(fault_ff)})
		else $error("status read mismatch");
endmodule

// ### tb/lpc_host_model.sv
// host controller model issuing one decode request per bench handshake
`timescale 1ns/1ps

module lpc_host_model (
	// link clock and main reset
	input  wire logic        lpc_clk,
	input  wire logic        rst,
	// request from the bench, held until ack
	input  wire logic        go,
	input  wire logic        mem,
	input  wire logic [31:0] addr,
	output logic             ack,
	// decoder link
	output logic             cyc_start,
	output logic             cyc_mem,
	output logic      [31:0] cyc_addr,
	input  wire logic        cyc_done
);
	logic go_s1;
	logic go_s2;
	logic wait_ff;

	always_ff @(posedge lpc_clk or posedge rst) begin
		if (rst) begin
			{go_s1, go_s2, wait_ff, ack, cyc_start, cyc_mem} <= 6'h00;
			cyc_addr <= 32'h0000_0000;
		end else begin
			go_s1 <= go;
			go_s2 <= go_s1;
			cyc_start <= 1'b0;
			// next request only after the previous answer
			if (go_s2 && !ack && !wait_ff && !cyc_start) begin
				cyc_start <= 1'b1;
				cyc_mem <= mem;
				cyc_addr <= addr;
				wait_ff <= 1'b1;
			end else begin
				// lines not qualified by a start keep changing
				cyc_addr <= ~cyc_addr;
				cyc_mem <= ~cyc_mem;
			end
			if (wait_ff && cyc_done) begin
				wait_ff <= 1'b0;
				ack <= 1'b1;
			end
			if (!go_s2) begin
				ack <= 1'b0;
			end
		end
	end
endmodule

// ### tb/tb.sv
// self-checking bench for the base address decoder
`timescale 1ns/1ps

module tb;
	logic        sys_clk = 1'b0;
	logic        lpc_clk = 1'b0;
	logic        rst = 1'b1;
	logic        host_domain_reset_n = 1'b1;
	logic        cfg_wr = 1'b0;
	logic        cfg_rd = 1'b0;
	logic [7:0]  cfg_addr = 8'h00;
	logic [7:0]  cfg_wdata = 8'h00;
	logic [7:0]  cfg_rdata;
	logic [15:0] bar_init_addr = 16'h0000;
	logic        host_bus_internal_fault_flag;
	logic        bar_conflict_flag;
	logic        cyc_start, cyc_mem, cyc_done, cyc_claim;
	logic [31:0] cyc_addr;
	logic [6:0]  logical_unit_number;
	logic [23:0] cyc_xlat_addr;
	logic        go = 1'b0;
	logic        mem = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic        ack;
	int          errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	logic [7:0]  t_ofs [14] = '{8'h60, 8'h64, 8'h68, 8'h78, 8'h88, 8'h8c, 8'h90, 8'h94,
		8'h98, 8'h9c, 8'hc0, 8'hc6, 8'hcc, 8'hd2};
	logic [47:0] t_rst [14] = '{48'h002e0c01, 48'h0000000f, 48'h00000707, 48'h00600104,
		48'h00620304, 48'h00660407, 48'h00000507, 48'h00920600, 48'h00000901,
		48'h00000b3f, 48'h000000000901, 48'h000000620304, 48'h000000660407, 48'h00000000000f};

	always #12.5 sys_clk = ~sys_clk;
	always #3 lpc_clk = ~lpc_clk;

	lpc_io_bar_address_decoder i_lpc_io_bar_address_decoder (
		.sys_clk(sys_clk), .rst(rst), .host_domain_reset_n(host_domain_reset_n),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .bar_init_addr(bar_init_addr),
		.host_bus_internal_fault_flag(host_bus_internal_fault_flag),
		.bar_conflict_flag(bar_conflict_flag), .lpc_clk(lpc_clk), .cyc_start(cyc_start),
		.cyc_mem(cyc_mem), .cyc_addr(cyc_addr), .cyc_done(cyc_done), .cyc_claim(cyc_claim),
		.logical_unit_number(logical_unit_number), .cyc_xlat_addr(cyc_xlat_addr));

	lpc_host_model i_lpc_host_model (
		.lpc_clk(lpc_clk), .rst(rst), .go(go), .mem(mem), .addr(addr), .ack(ack),
		.cyc_start(cyc_start), .cyc_mem(cyc_mem), .cyc_addr(cyc_addr), .cyc_done(cyc_done));

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input int n, output logic [47:0] v);
		v = 48'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			cfg_rd <= 1'b1;
			cfg_addr <= a + 8'(i);
			@(posedge sys_clk);
			cfg_rd <= 1'b0;
			#1 v[8*i +: 8] = cfg_rdata;
		end
	endtask

	// one host cycle through the model, results stand afterwards
	task automatic cyc(input logic m, input logic [31:0] a);
		int k;
		@(posedge sys_clk);
		mem <= m;
		addr <= a;
		go <= 1'b1;
		for (k = 0; k < 200 && ack !== 1'b1; k++) @(posedge sys_clk);
		chk("link_answer", 48'(k < 200), 48'h1);
		go <= 1'b0;
		for (k = 0; k < 200 && ack !== 1'b0; k++) @(posedge sys_clk);
		chk("link_release", 48'(k < 200), 48'h1);
	endtask

	function automatic logic [23:0] xl(logic [5:0] f, logic [7:0] a, logic [7:0] m);
		return {8'h00, f, 2'b00, a & m};
	endfunction

	task automatic dchk(input logic c, input logic [6:0] l, input logic [23:0] x);
		chk("cyc_claim", cyc_claim, c);
		if (c) begin
			chk("unit_number", logical_unit_number, l);
			chk("xlat_addr", cyc_xlat_addr, x);
		end
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	initial begin
		logic [47:0] v;
		logic [15:0] h, a, p, b;
		logic [31:0] mh, ma;
		void'($urandom(32'h9fb1));
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 14; i++) begin
			rd(t_ofs[i], i < 10 ? 4 : 6, v);
			chk("reset_value", v, t_rst[i]);
		end
		// read-only bytes ignore writes
		h = {4'h1, 12'($urandom)};
		wr(8'h68, 8'($urandom));
		wr(8'h69, 8'h7f);
		wr(8'h6a, h[7:0]);
		wr(8'h6b, h[15:8]);
		rd(8'h68, 4, v);
		chk("serial_bar", v, {16'h0, h, 16'h0707});
		cyc(1'b0, {16'h0, h});
		dchk(1'b0, 7'h00, 24'h0);
		wr(8'h69, 8'hff);
		rd(8'h69, 1, v);
		chk("serial_valid", v, 48'h87);
		a = h ^ 16'($urandom & 16'h0007);
		cyc(1'b0, {16'h0, a});
		dchk(1'b1, 7'h07, xl(6'h07, a[7:0], 8'h07));
		cyc(1'b0, {16'h0, h ^ 16'h0008});
		dchk(1'b0, 7'h00, 24'h0);
		// overlapping decode of two units
		wr(8'h8d, 8'h80);
		wr(8'h8e, h[7:0]);
		wr(8'h8f, h[15:8]);
		cyc(1'b0, {16'h0, h});
		dchk(1'b1, 7'h07, xl(6'h07, h[7:0], 8'h07));
		chk("fault_flag", host_bus_internal_fault_flag, 48'h1);
		chk("conflict_flag", bar_conflict_flag, 48'h1);
		rd(8'hf0, 1, v);
		chk("status", v, 48'h03);
		wr(8'hf0, 8'h03);
		rd(8'hf0, 1, v);
		chk("status_clear", v, 48'h00);
		chk("fault_clear", host_bus_internal_fault_flag, 48'h0);
		wr(8'h8d, 8'h00);
		// legacy unit decodes its own range
		wr(8'h95, 8'h80);
		cyc(1'b0, 32'h0000_0096);
		chk("legacy_claim", cyc_claim, 48'h1);
		chk("legacy_unit", logical_unit_number, 48'h06);
		cyc(1'b0, 32'h0000_0093);
		chk("legacy_miss", cyc_claim, 48'h0);
		// memory base register
		mh = $urandom;
		wr(8'hc7, 8'h80);
		for (int i = 0; i < 4; i++) wr(8'hc8 + 8'(i), mh[8*i +: 8]);
		rd(8'hc6, 6, v);
		chk("mem_bar", v, {mh, 16'h8304});
		ma = mh ^ ($urandom & 32'h0000_0004);
		cyc(1'b1, ma);
		dchk(1'b1, 7'h03, xl(6'h03, ma[7:0], 8'h04));
		cyc(1'b1, mh ^ 32'h0001_0000);
		dchk(1'b0, 7'h00, 24'h0);
		// config port moves through the shadow byte
		p = {4'h2, 12'($urandom)};
		wr(8'h61, 8'h80);
		wr(8'h62, p[7:0]);
		rd(8'h60, 4, v);
		chk("cfg_shadow", v, 48'h002e8c01);
		wr(8'h63, p[15:8]);
		rd(8'h60, 4, v);
		chk("cfg_bar", v, {16'h0, p, 16'h8c01});
		cyc(1'b0, {16'h0, p ^ 16'h0001});
		dchk(1'b1, 7'h0c, xl(6'h0c, p[7:0] ^ 8'h01, 8'h01));
		// host domain reset reloads the config port address and restores the other base registers to their reset values
		b = 16'($urandom);
		@(posedge sys_clk);
		bar_init_addr <= b;
		host_domain_reset_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		host_domain_reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(8'h60, 4, v);
		chk("cfg_reload", v, {16'h0, b, 16'h8c01});
		rd(8'h68, 4, v);
		chk("serial_reload", v, 48'h00000707);
		end_of_test();
	end
endmodule
